/* spbc_pkg.sv */
// serial port package: register indices, field positions, mode codes, state types
// assumes 8-bit registers behind a 32-bit classic wishbone slave, one word each
package spbc_pkg;
    localparam int unsigned CLK_HZ     = 10_000_000;
    // oscillator clocks per machine cycle; the clock is the oscillator
    localparam int unsigned MC_DIV     = 12;
    localparam logic [3:0]  MC_LAST    = 4'(MC_DIV - 1);
    localparam logic [3:0]  MC_HALF    = 4'(MC_DIV / 2);
    localparam logic [3:0]  SAMPLE_MID = 4'h7;
    localparam logic [3:0]  SAMPLE_END = 4'hf;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_WIDTH = 8;

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_POWER_CONTROL  = 10'h087;
    localparam logic [9:0] IDX_GT_CONTROL     = 10'h088;
    localparam logic [9:0] IDX_GT_COUNT_LOW   = 10'h08b;
    localparam logic [9:0] IDX_GT_RELOAD_HIGH = 10'h08d;
    localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h098;
    localparam logic [9:0] IDX_SERIAL_DATA    = 10'h099;
    localparam logic [9:0] IDX_ST_CONTROL     = 10'h0c8;
    localparam logic [9:0] IDX_RCAP_LOW       = 10'h0ca;
    localparam logic [9:0] IDX_RCAP_HIGH      = 10'h0cb;
    localparam logic [9:0] IDX_ST_COUNT_LOW   = 10'h0cc;
    localparam logic [9:0] IDX_ST_COUNT_HIGH  = 10'h0cd;

    // serial_control fields
    localparam int SC_MP_FILTER = 5;
    localparam int SC_RX_ENABLE = 4;
    localparam int SC_TX_NINTH  = 3;
    localparam int SC_RX_NINTH  = 2;
    localparam int SC_TX_DONE   = 1;
    localparam int SC_RX_DONE   = 0;
    // power_control and general timer control fields
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int GT_RUN         = 6;
    // second_timer_control fields
    localparam int ST_OVF_FLAG = 7;
    localparam int ST_EXT_FLAG = 6;
    localparam int ST_RX_CLK   = 5;
    localparam int ST_TX_CLK   = 4;
    localparam int ST_EXT_EN   = 3;
    localparam int ST_RUN      = 2;
    localparam int ST_COUNTER  = 1;
    localparam int ST_CAPTURE  = 0;

    localparam logic IDLE_LINE = 1'b1;

    // serial mode field codes
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;
    localparam logic [1:0] MODE_UART9 = 2'h3;
    // bits per frame: shift byte, 8-bit frame, 9-bit frame
    localparam logic [3:0] NB_SHIFT = 4'h8;
    localparam logic [3:0] NB_UART8 = 4'ha;
    localparam logic [3:0] NB_UART9 = 4'hb;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_UART} spbc_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_UART} spbc_rx_e;
endpackage

/* spbc_serial_port.sv */
// serial port with baud generation, two timers and a transmit fifo
// assumes a classic wishbone master on clk_i and the serial pins synchronised here
// Overview of operation
// - two-bit mode field selects shift register, 8-bit UART, or two 9-bit UARTs
// - modes 2/3 with filter on: received ninth bit 0 leaves receive flag clear
// - mode 1 with filter on: receive flag set only after a valid stop bit
// - receive flag set after 8th bit (mode 0) or mid stop; software clears
// - mode 0 shifts at oscillator over 12, no timer involved
// - mode 1 rate comes from general timer or second timer overflow
// - general timer auto-reloads; rate K*osc/(32*12*(256-reload high))
// - K is 1 with baud-double clear and 2 with it set
// - baud-double is bit 7 of power_control at index 87h
// - second timer on its clock pin in baud mode: rate is overflow/16
// - second timer internal in baud mode: rate osc/(32*(65536-reload))
// - mode 2 uses no timer: osc/32 with baud-double, osc/64 without
// - mode 3 makes its rate exactly as mode 1
// - with external enable and both clock-select bits clear, trigger falling edge also reloads or captures
// - clock-select bits pick second or general timer for receive, transmit
//
// The Wishbone slave port was left to the implementer.

module spbc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output      logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output      logic             out_valid_o,
    input  wire logic             out_ready_i,
    output      logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
    } spbc_fifo_s;

    spbc_fifo_s q;
    spbc_fifo_s d;
    logic       push;
    logic       pop;

    assign in_ready_o  = q.count != (AW+1)'(DEPTH);
    assign out_valid_o = q.count != '0;
    assign out_data_o  = q.mem[q.rd];

    always_comb begin
        d    = q;
        push = in_valid_i & in_ready_o;
        pop  = out_valid_o & out_ready_i;
        if (push) begin
            d.mem[q.wr] = in_data_i;
            d.wr        = q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = q.rd + AW'(1);
        end
        d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module spbc_serial_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    input  wire logic        rxd_i,
    output      logic        rxd_o,
    output      logic        rxd_oe_o,
    output      logic        txd_o,
    input  wire logic        second_timer_clock_pin_i,
    input  wire logic        second_timer_ext_trigger_i
);
    typedef struct packed {
        logic               ack;
        logic [31:0]        dat;
        logic               txd;
        logic               rxd;
        logic               rxd_oe;
        logic [7:0]         serial_control;
        logic               baud_double_bit;
        logic               t1run;
        logic [7:0]         tl1;
        logic [7:0]         th1;
        logic               t1half;
        logic [7:0]         second_timer_control;
        logic [15:0]        t2cnt;
        logic [15:0]        rcap;
        logic [3:0]         mc;
        logic [1:0]         pre;
        // sync chains: [0] first stage, [1] second stage, [2] previous second
        logic [2:0]         rxs;
        logic [2:0]         t2s;
        logic [2:0]         exs;
        spbc_pkg::spbc_tx_e txst;
        logic [3:0]         txsub;
        logic [3:0]         txbits;
        logic [10:0]        txsh;
        spbc_pkg::spbc_rx_e rxst;
        logic [3:0]         rxsub;
        logic [3:0]         rxbits;
        logic [9:0]         rxsh;
        logic [7:0]         rxbuf;
    } spbc_state_s;

    spbc_state_s q;
    spbc_state_s d;

    logic       fifo_ready;
    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic       fifo_push;
    logic       tx_pop;
    logic       req;
    logic       wr_go;
    logic [9:0] idx;
    logic [1:0] mode;
    logic       mc_tick;
    logic       t1_ovf;
    logic       t1_tick;
    logic       baud;
    logic       t2_inc;
    logic       t2_ovf;
    logic       ext;
    logic       m2_tick;
    logic       rx_tick;
    logic       tx_tick;
    logic       ti_set;
    logic       ri_set;
    logic       rx_in;
    logic       ren;
    logic [3:0] nb;
    logic       ninth;
    logic       shift_act;

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign txd_o    = q.txd;
    assign rxd_o    = q.rxd;
    assign rxd_oe_o = q.rxd_oe;

    // a full fifo holds off the bus write until a slot frees up
    spbc_fifo #(
        .WIDTH (spbc_pkg::FIFO_WIDTH),
        .DEPTH (spbc_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (wb_dat_i[7:0]),
        .out_valid_o (fifo_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (fifo_data)
    );

    assign req       = wb_cyc_i & wb_stb_i & ~q.ack;
    assign idx       = wb_adr_i[11:2];
    assign fifo_push = req & wb_we_i & wb_sel_i[0] & (idx == spbc_pkg::IDX_SERIAL_DATA);

    always_comb begin
        d         = q;
        tx_pop    = 1'b0;
        ti_set    = 1'b0;
        ri_set    = 1'b0;
        mode      = q.serial_control[7:6];
        rx_in     = q.rxs[1];
        ren       = q.serial_control[spbc_pkg::SC_RX_ENABLE];
        nb        = mode[1] ? spbc_pkg::NB_UART9 : spbc_pkg::NB_UART8;
        ninth     = 1'b0;
        d.rxs     = {q.rxs[1:0], rxd_i};
        d.t2s     = {q.t2s[1:0], second_timer_clock_pin_i};
        d.exs     = {q.exs[1:0], second_timer_ext_trigger_i};

        // machine cycle and fast prescalers
        mc_tick = q.mc == spbc_pkg::MC_LAST;
        d.mc    = mc_tick ? 4'h0 : q.mc + 4'h1;
        d.pre   = q.pre + 2'h1;

        // general timer, 8-bit auto-reload from the reload high byte
        t1_ovf = q.t1run & mc_tick & (q.tl1 == 8'hff);
        if (q.t1run & mc_tick) begin
            d.tl1 = t1_ovf ? q.th1 : q.tl1 + 8'h01;
        end
        if (t1_ovf) begin
            d.t1half = ~q.t1half;
        end
        t1_tick = t1_ovf & (q.baud_double_bit | q.t1half);

        // second timer
        baud   = q.second_timer_control[spbc_pkg::ST_RX_CLK] | q.second_timer_control[spbc_pkg::ST_TX_CLK];
        t2_inc = q.second_timer_control[spbc_pkg::ST_RUN] & (q.second_timer_control[spbc_pkg::ST_COUNTER]
                 ? (q.t2s[2] & ~q.t2s[1])
                 : (baud ? q.pre[0] : mc_tick));
        t2_ovf = t2_inc & (q.t2cnt == 16'hffff);
        ext    = q.exs[2] & ~q.exs[1] & q.second_timer_control[spbc_pkg::ST_EXT_EN] & ~baud;
        if (t2_inc) begin
            d.t2cnt = q.t2cnt + 16'h0001;
        end
        if (t2_ovf & (baud | ~q.second_timer_control[spbc_pkg::ST_CAPTURE])) begin
            d.t2cnt = q.rcap;
        end
        if (ext) begin
            if (q.second_timer_control[spbc_pkg::ST_CAPTURE]) begin
                d.rcap = q.t2cnt;
            end else begin
                d.t2cnt = q.rcap;
            end
        end

        // sample ticks, sixteen per bit time
        m2_tick = q.baud_double_bit ? q.pre[0] : (q.pre == 2'h3);
        rx_tick = (mode == spbc_pkg::MODE_FIXED) ? m2_tick
                : (q.second_timer_control[spbc_pkg::ST_RX_CLK] ? t2_ovf : t1_tick);
        tx_tick = (mode == spbc_pkg::MODE_FIXED) ? m2_tick
                : (q.second_timer_control[spbc_pkg::ST_TX_CLK] ? t2_ovf : t1_tick);

        // transmitter
        case (q.txst)
            spbc_pkg::TX_IDLE: begin
                if (fifo_valid) begin
                    if (mode == spbc_pkg::MODE_SHIFT) begin
                        if (mc_tick & (q.rxst == spbc_pkg::RX_IDLE)) begin
                            d.txsh   = {3'h7, fifo_data};
                            d.txbits = spbc_pkg::NB_SHIFT;
                            d.txst   = spbc_pkg::TX_SHIFT;
                            tx_pop   = 1'b1;
                        end
                    end else if (tx_tick) begin
                        d.txsh   = mode[1] ? {1'b1, q.serial_control[spbc_pkg::SC_TX_NINTH], fifo_data, 1'b0}
                                           : {2'h3, fifo_data, 1'b0};
                        d.txbits = nb;
                        d.txsub  = 4'h0;
                        d.txst   = spbc_pkg::TX_UART;
                        tx_pop   = 1'b1;
                    end
                end
            end
            spbc_pkg::TX_SHIFT: begin
                if (mc_tick) begin
                    d.txsh   = {1'b1, q.txsh[10:1]};
                    d.txbits = q.txbits - 4'h1;
                    if (q.txbits == 4'h1) begin
                        ti_set = 1'b1;
                        d.txst = spbc_pkg::TX_IDLE;
                    end
                end
            end
            spbc_pkg::TX_UART: begin
                if (tx_tick) begin
                    d.txsub = q.txsub + 4'h1;
                    if (q.txsub == spbc_pkg::SAMPLE_END) begin
                        d.txsh   = {1'b1, q.txsh[10:1]};
                        d.txbits = q.txbits - 4'h1;
                        ti_set   = q.txbits == 4'h2;
                        if (q.txbits == 4'h1) begin
                            d.txst = spbc_pkg::TX_IDLE;
                        end
                    end
                end
            end
            default: d.txst = spbc_pkg::TX_IDLE;
        endcase

        // receiver
        case (q.rxst)
            spbc_pkg::RX_IDLE: begin
                if (ren) begin
                    if (mode == spbc_pkg::MODE_SHIFT) begin
                        if (~q.serial_control[spbc_pkg::SC_RX_DONE] & (q.txst == spbc_pkg::TX_IDLE)
                            & ~fifo_valid & mc_tick) begin
                            d.rxst   = spbc_pkg::RX_SHIFT;
                            d.rxbits = spbc_pkg::NB_SHIFT;
                        end
                    end else if (q.rxs[2] & ~q.rxs[1]) begin
                        d.rxst   = spbc_pkg::RX_UART;
                        d.rxsub  = 4'h0;
                        d.rxbits = nb;
                    end
                end
            end
            spbc_pkg::RX_SHIFT: begin
                if (~ren) begin
                    d.rxst = spbc_pkg::RX_IDLE;
                end else if (mc_tick) begin
                    d.rxsh   = {rx_in, q.rxsh[9:1]};
                    d.rxbits = q.rxbits - 4'h1;
                    if (q.rxbits == 4'h1) begin
                        d.rxbuf = {rx_in, q.rxsh[9:3]};
                        ri_set  = 1'b1;
                        d.rxst  = spbc_pkg::RX_IDLE;
                    end
                end
            end
            spbc_pkg::RX_UART: begin
                if (~ren) begin
                    d.rxst = spbc_pkg::RX_IDLE;
                end else if (rx_tick) begin
                    d.rxsub = q.rxsub + 4'h1;
                    if (q.rxsub == spbc_pkg::SAMPLE_MID) begin
                        d.rxsh   = {rx_in, q.rxsh[9:1]};
                        d.rxbits = q.rxbits - 4'h1;
                        if ((q.rxbits == nb) & rx_in) begin
                            d.rxst = spbc_pkg::RX_IDLE;
                        end else if (q.rxbits == 4'h1) begin
                            // mode 1 filters on the stop bit, modes 2/3 on the ninth bit
                            ninth  = mode[1] ? q.rxsh[9] : rx_in;
                            d.rxst = spbc_pkg::RX_IDLE;
                            if (~q.serial_control[spbc_pkg::SC_RX_DONE]
                                & (~q.serial_control[spbc_pkg::SC_MP_FILTER] | ninth)) begin
                                d.rxbuf = mode[1] ? q.rxsh[8:1] : q.rxsh[9:2];
                                d.serial_control[spbc_pkg::SC_RX_NINTH] = ninth;
                                ri_set  = 1'b1;
                            end
                        end
                    end
                end
            end
            default: d.rxst = spbc_pkg::RX_IDLE;
        endcase

        // bus slave, one-cycle answer except a write to a full fifo
        d.ack = req & ~(fifo_push & ~fifo_ready);
        wr_go = d.ack & wb_we_i & wb_sel_i[0];
        if (wr_go) begin
            case (idx)
                spbc_pkg::IDX_POWER_CONTROL:  d.baud_double_bit = wb_dat_i[spbc_pkg::PC_BAUD_DOUBLE];
                spbc_pkg::IDX_GT_CONTROL:     d.t1run = wb_dat_i[spbc_pkg::GT_RUN];
                spbc_pkg::IDX_GT_COUNT_LOW:   d.tl1 = wb_dat_i[7:0];
                spbc_pkg::IDX_GT_RELOAD_HIGH: d.th1 = wb_dat_i[7:0];
                spbc_pkg::IDX_SERIAL_CONTROL: d.serial_control = wb_dat_i[7:0];
                spbc_pkg::IDX_ST_CONTROL:     d.second_timer_control = wb_dat_i[7:0];
                spbc_pkg::IDX_RCAP_LOW:       d.rcap[7:0] = wb_dat_i[7:0];
                spbc_pkg::IDX_RCAP_HIGH:      d.rcap[15:8] = wb_dat_i[7:0];
                spbc_pkg::IDX_ST_COUNT_LOW:   d.t2cnt[7:0] = wb_dat_i[7:0];
                spbc_pkg::IDX_ST_COUNT_HIGH:  d.t2cnt[15:8] = wb_dat_i[7:0];
                default: ;
            endcase
        end
        d.dat = 32'h0000_0000;
        if (d.ack & ~wb_we_i) begin
            case (idx)
                spbc_pkg::IDX_POWER_CONTROL:  d.dat[7] = q.baud_double_bit;
                spbc_pkg::IDX_GT_CONTROL:     d.dat[spbc_pkg::GT_RUN] = q.t1run;
                spbc_pkg::IDX_GT_COUNT_LOW:   d.dat[7:0] = q.tl1;
                spbc_pkg::IDX_GT_RELOAD_HIGH: d.dat[7:0] = q.th1;
                spbc_pkg::IDX_SERIAL_CONTROL: d.dat[7:0] = q.serial_control;
                spbc_pkg::IDX_SERIAL_DATA:    d.dat[7:0] = q.rxbuf;
                spbc_pkg::IDX_ST_CONTROL:     d.dat[7:0] = q.second_timer_control;
                spbc_pkg::IDX_RCAP_LOW:       d.dat[7:0] = q.rcap[7:0];
                spbc_pkg::IDX_RCAP_HIGH:      d.dat[7:0] = q.rcap[15:8];
                spbc_pkg::IDX_ST_COUNT_LOW:   d.dat[7:0] = q.t2cnt[7:0];
                spbc_pkg::IDX_ST_COUNT_HIGH:  d.dat[7:0] = q.t2cnt[15:8];
                default: ;
            endcase
        end

        // hardware flag sets win over a software write in the same cycle
        if (ti_set) begin
            d.serial_control[spbc_pkg::SC_TX_DONE] = 1'b1;
        end
        if (ri_set) begin
            d.serial_control[spbc_pkg::SC_RX_DONE] = 1'b1;
        end
        if (t2_ovf & ~baud) begin
            d.second_timer_control[spbc_pkg::ST_OVF_FLAG] = 1'b1;
        end
        if (ext) begin
            d.second_timer_control[spbc_pkg::ST_EXT_FLAG] = 1'b1;
        end

        // pins: mode 0 puts the shift clock on txd, low for the first half
        shift_act = (d.txst == spbc_pkg::TX_SHIFT) | (d.rxst == spbc_pkg::RX_SHIFT);
        d.txd     = shift_act ? (d.mc >= spbc_pkg::MC_HALF)
                  : ((d.txst == spbc_pkg::TX_UART) ? d.txsh[0] : spbc_pkg::IDLE_LINE);
        d.rxd_oe  = d.txst == spbc_pkg::TX_SHIFT;
        d.rxd     = d.rxd_oe ? d.txsh[0] : spbc_pkg::IDLE_LINE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q     <= '0;
            q.txd <= spbc_pkg::IDLE_LINE;
            q.rxd <= spbc_pkg::IDLE_LINE;
            q.rxs <= {3{spbc_pkg::IDLE_LINE}};
            q.t2s <= {3{spbc_pkg::IDLE_LINE}};
            q.exs <= {3{spbc_pkg::IDLE_LINE}};
        end else begin
            q <= d;
        end
    end
endmodule

/* spbc_serial_port_assertions.sv */
// checker for the serial port: bus handshake and mode 0 shift framing
// assumes it is bound to spbc_serial_port and sees only that module's ports
module spbc_checker (
    input logic        clk_i,
    input logic        rst_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [11:0] wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        rxd_i,
    input logic        rxd_o,
    input logic        rxd_oe_o,
    input logic        txd_o,
    input logic        second_timer_clock_pin_i,
    input logic        second_timer_ext_trigger_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        && (!wb_we_i || wb_adr_i[11:2] != spbc_pkg::IDX_SERIAL_DATA) |=> wb_ack_o)
        else $error("answer not in the next cycle");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside an answer");
    chk_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_shift_clock: assert property (rxd_oe_o && $fell(txd_o) |-> (!txd_o)[*6] ##1 txd_o[*6])
        else $error("shift clock phases wrong");
    chk_shift_data: assert property (rxd_oe_o && $past(rxd_oe_o) && !$fell(txd_o) |-> $stable(rxd_o))
        else $error("shift data moved inside a bit");
    chk_shift_bytes: assert property ($rose(rxd_oe_o) |-> ##95 rxd_oe_o)
        else $error("shift byte shorter than eight bits");
endmodule
bind spbc_serial_port spbc_checker spbc_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
    .second_timer_clock_pin_i(second_timer_clock_pin_i),
    .second_timer_ext_trigger_i(second_timer_ext_trigger_i)
);

/* spbc_node.sv */
// far serial node: sends and receives asynchronous frames
// assumes bit times in clock cycles and a line that idles high by pull-up
module spbc_node (
    input  logic clk_i,
    input  logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    // start bit, then n bits lsb first; the caller supplies ninth and stop bits
    task automatic send(input logic [9:0] bits, input int n, input int bitc);
        @(posedge clk_i);
        line_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (bitc) @(posedge clk_i);
            line_o <= bits[i];
        end
        repeat (bitc) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
    // mode 0 partner: next bit goes on the line at each shift clock rise
    task automatic shift_out(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge line_i);
            line_o <= b[i];
        end
        repeat (12) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
    // samples nine bits after the start bit at their middles
    task automatic recv(input int bitc, output logic [8:0] v);
        @(posedge clk_i);
        while (line_i !== 1'b0) @(posedge clk_i);
        repeat (bitc / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bitc) @(posedge clk_i);
            v[i] = line_i;
        end
    endtask
endmodule

/* spbc_serial_port_tb.sv */
// bench for the serial port: registers over wishbone, frames both ways, fifo fill
// assumes the node model in spbc_node.sv and the bound checker
module spbc_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] SC = spbc_pkg::IDX_SERIAL_CONTROL;
    localparam logic [9:0] SD = spbc_pkg::IDX_SERIAL_DATA;
    localparam logic [9:0] PC = spbc_pkg::IDX_POWER_CONTROL;
    localparam logic [9:0] ST = spbc_pkg::IDX_ST_CONTROL;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [11:0] adr   = 12'h000;
    logic [7:0]  wd    = 8'h00;
    logic [31:0] dat_o;
    logic        ack;
    logic        rxd_o;
    logic        oe;
    logic        txd;
    logic        node_line;
    logic        t2_pin = 1'b1;
    logic        t2_ext = 1'b1;
    logic [8:0]  rv;
    int          n_wait;
    int          fail_count = 0;
    int          n_tests = 0;
    always #50 clk_i = ~clk_i;
    spbc_serial_port spbc_serial_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i({24'h00_0000, wd}), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rxd_i(oe ? rxd_o : node_line), .rxd_o(rxd_o), .rxd_oe_o(oe), .txd_o(txd),
        .second_timer_clock_pin_i(t2_pin), .second_timer_ext_trigger_i(t2_ext));
    spbc_node spbc_node_i (.clk_i(clk_i), .line_i(txd), .line_o(node_line));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20000);
        rv = {1'b0, dat_o[7:0]};
        n_wait = n;
        if (ack !== 1'b1) fail_count++;
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] i, input logic [8:0] exp);
        wb(1'b0, i, 8'h00);
        chk(rv, exp);
    endtask
    task automatic tx(input logic [7:0] sc, input logic [7:0] d, input int bitc,
                      input logic [8:0] exp);
        logic [8:0] v;
        wb(1'b1, SC, sc);
        wb(1'b1, SD, d);
        spbc_node_i.recv(bitc, v);
        chk(v, exp);
        repeat (bitc) @(posedge clk_i);
        rd(SC, {1'b0, sc | 8'h02});
    endtask
    task automatic rx(input logic [7:0] sc, input logic [9:0] bits, input int n,
                      input int bitc, input logic [7:0] esc, input logic [7:0] ed);
        wb(1'b1, SC, sc);
        spbc_node_i.send(bits, n, bitc);
        repeat (bitc) @(posedge clk_i);
        rd(SC, {1'b0, esc});
        if (esc[0]) rd(SD, {1'b0, ed});
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #5_000_000;
        fail_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(PC, 9'h000);
        rd(SC, 9'h000);
        wb(1'b1, PC, 8'hff);
        rd(PC, 9'h080);
        wb(1'b1, 10'h3ff, 8'hff);
        rd(10'h3ff, 9'h000);
        tx(8'h88, 8'ha5, 32, 9'h1a5);
        wb(1'b1, PC, 8'h00);
        tx(8'h80, 8'h5a, 64, 9'h05a);
        wb(1'b1, PC, 8'h80);
        rx(8'hb0, 10'h2c3, 10, 32, 8'hb0, 8'h00);
        rx(8'hb0, 10'h33c, 10, 32, 8'hb5, 8'h3c);
        rx(8'h80, 10'h33c, 10, 32, 8'h80, 8'h00);
        wb(1'b1, spbc_pkg::IDX_GT_RELOAD_HIGH, 8'hff);
        wb(1'b1, spbc_pkg::IDX_GT_CONTROL, 8'h40);
        tx(8'h50, 8'h96, 192, 9'h196);
        rx(8'h70, 10'h055, 9, 192, 8'h70, 8'h00);
        rx(8'h70, 10'h1aa, 9, 192, 8'h75, 8'haa);
        for (int i = 0; i < 4; i++) wb(1'b1, spbc_pkg::IDX_RCAP_LOW + 10'(i), 8'hff);
        wb(1'b1, spbc_pkg::IDX_ST_CONTROL, 8'h34);
        tx(8'hc8, 8'h0f, 32, 9'h10f);
        rx(8'hd0, 10'h2f0, 10, 32, 8'hd1, 8'hf0);
        wb(1'b1, ST, 8'h0b);
        wb(1'b1, spbc_pkg::IDX_ST_COUNT_LOW, 8'h12);
        wb(1'b1, spbc_pkg::IDX_ST_COUNT_HIGH, 8'h34);
        wb(1'b1, ST, 8'h0f);
        t2_pin <= 1'b0;
        repeat (4) @(posedge clk_i);
        t2_pin <= 1'b1;
        repeat (4) @(posedge clk_i);
        t2_ext <= 1'b0;
        repeat (4) @(posedge clk_i);
        t2_ext <= 1'b1;
        rd(spbc_pkg::IDX_RCAP_LOW, 9'h013);
        rd(ST, 9'h04f);
        wb(1'b1, SC, 8'h00);
        wb(1'b1, SD, 8'hc3);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            rv[i] = rxd_o;
        end
        chk(rv, 9'h0c3);
        for (int i = 0; i < 18; i++) wb(1'b1, SD, 8'(i));
        chk(9'(n_wait > 2), 9'h001);
        repeat (2000) @(posedge clk_i);
        rd(SC, 9'h002);
        wb(1'b1, SC, 8'h10);
        spbc_node_i.shift_out(8'h3c);
        rd(SC, 9'h011);
        rd(SD, 9'h03c);
        results();
    end
endmodule
